// ### hdl/lmr_mode_regs.sv
`timescale 1ns/10ps
module lmr_mode_regs #(
	parameter logic [7:0] REVISION_CODE = 8'h00, // Arbitrary value.
	parameter logic [1:0] MEM_TYPE      = lmr_pkg::TYPE_S4_SDRAM,
	parameter logic [3:0] DENSITY       = lmr_pkg::DENSITY_2GB,
	parameter logic [1:0] IO_WIDTH      = lmr_pkg::WIDTH_X32,
	parameter int         NUM_BANKS     = lmr_pkg::BANKS_DEFAULT
) (
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic       mode_write_in,
	input  wire logic       mode_read_in,
	input  wire logic [7:0] register_address_in,
	input  wire logic [7:0] operand_bits_in,
	input  wire logic       calibration_pin_to_supply_in,
	output logic [7:0]      operand_bits_out,
	output logic            read_valid_out,
	output logic [7:0]      test_mode_out,
	output logic [7:0]      partial_refresh_bank_mask_out,
	output logic            cal_init_out,
	output logic            cal_long_out,
	output logic            cal_short_out,
	output logic            cal_reset_out,
	output logic            default_cal_out,
	output logic            strap_valid_out
);
	logic       write_cal;
	logic       write_test;
	logic       write_mask;
	logic       cal_known;
	logic [3:0] cal_onehot;
	logic [7:0] bank_enable;
	logic [7:0] org_value;
	logic [7:0] read_nxt;
	logic       strap_tied_r;
	logic       strap_taken_r;

	assign write_cal  = mode_write_in && (register_address_in == lmr_pkg::ADDR_IO_CALIBRATION);
	assign write_test = mode_write_in && (register_address_in == lmr_pkg::ADDR_TEST_MODE);
	assign write_mask = mode_write_in && (register_address_in == lmr_pkg::ADDR_BANK_MASK);

	assign org_value[lmr_pkg::ORG_TYPE_LSB +: 2]    = MEM_TYPE;
	assign org_value[lmr_pkg::ORG_DENSITY_LSB +: 4] = DENSITY;
	assign org_value[lmr_pkg::ORG_WIDTH_LSB +: 2]   = IO_WIDTH;

	lmr_cal_decode u_cal_decode (
		.code_in         (operand_bits_in),
		.known_out       (cal_known),
		.kind_onehot_out (cal_onehot)
	);

	// Mask bits for banks that do not exist are forced off.
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_bank
			assign bank_enable[b] = (b < NUM_BANKS);
		end
	endgenerate

	// The pin connection may not change once powered, so one sample after reset is enough.
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			strap_taken_r <= 1'b0;
			strap_tied_r  <= 1'b0;
		end else if (!strap_taken_r) begin
			strap_taken_r <= 1'b1;
			strap_tied_r  <= calibration_pin_to_supply_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			strap_valid_out <= 1'b0;
		end else begin
			strap_valid_out <= strap_taken_r;
		end
	end

	// Reads of write-only and reserved addresses return a fixed harmless fill.
	always_comb begin
		case (register_address_in)
			lmr_pkg::ADDR_REVISION_TWO: read_nxt = REVISION_CODE;
			lmr_pkg::ADDR_ORGANISATION: read_nxt = org_value;
			default:                    read_nxt = lmr_pkg::READ_FILL;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			read_valid_out   <= 1'b0;
			operand_bits_out <= lmr_pkg::READ_FILL;
		end else begin
			read_valid_out <= mode_read_in;
			if (mode_read_in) begin
				operand_bits_out <= read_nxt;
			end
		end
	end

	// Test codes are only stored; the block gives them no meaning.
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			test_mode_out <= lmr_pkg::TEST_MODE_RESET;
		end else if (write_test) begin
			test_mode_out <= operand_bits_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			partial_refresh_bank_mask_out <= lmr_pkg::BANK_MASK_RESET;
		end else if (write_mask) begin
			partial_refresh_bank_mask_out <= operand_bits_in & bank_enable;
		end
	end

	// A reserved code or a tied pin yields no pulse at all; until the pin is sampled,
	// commands are ignored too, since the calibration mode is not yet known.
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			cal_init_out  <= 1'b0;
			cal_long_out  <= 1'b0;
			cal_short_out <= 1'b0;
			cal_reset_out <= 1'b0;
		end else begin
			cal_init_out  <= 1'b0;
			cal_long_out  <= 1'b0;
			cal_short_out <= 1'b0;
			cal_reset_out <= 1'b0;
			if (write_cal && cal_known && strap_taken_r && !strap_tied_r) begin
				cal_init_out  <= cal_onehot[lmr_pkg::LMR_CAL_INIT];
				cal_long_out  <= cal_onehot[lmr_pkg::LMR_CAL_LONG];
				cal_short_out <= cal_onehot[lmr_pkg::LMR_CAL_SHORT];
				cal_reset_out <= cal_onehot[lmr_pkg::LMR_CAL_RESET];
			end
		end
	end

	// Default calibration holds from reset until an active calibration runs.
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			default_cal_out <= 1'b1;
		end else if (strap_taken_r && strap_tied_r) begin
			default_cal_out <= 1'b1;
		end else if (cal_reset_out) begin
			default_cal_out <= 1'b1;
		end else if (cal_init_out || cal_long_out || cal_short_out) begin
			default_cal_out <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	sequence s_write_at(logic [7:0] a);
		mode_write_in && !mode_read_in && register_address_in == a;
	endsequence

	sequence s_cal_write;
		s_write_at(lmr_pkg::ADDR_IO_CALIBRATION) ##0 (strap_taken_r && !strap_tied_r);
	endsequence

	a_revision_read: assert property (
		mode_read_in && register_address_in == lmr_pkg::ADDR_REVISION_TWO
		|=> read_valid_out && operand_bits_out == REVISION_CODE)
		else $error("Revision read returned wrong data.");

	a_org_read: assert property (
		mode_read_in && register_address_in == lmr_pkg::ADDR_ORGANISATION
		|=> operand_bits_out[1:0] == MEM_TYPE && operand_bits_out[5:2] == DENSITY
		&& operand_bits_out[7:6] == IO_WIDTH)
		else $error("Organisation read returned wrong fields.");

	a_test_store: assert property (
		s_write_at(lmr_pkg::ADDR_TEST_MODE) |=> test_mode_out == $past(operand_bits_in))
		else $error("Test mode write not stored.");

	// Back-to-back commands are legal, so a second write may keep the pulse up.
	a_cal_long_go: assert property (
		s_cal_write ##0 operand_bits_in == lmr_pkg::CAL_LONG
		|=> cal_long_out && !cal_short_out ##1 (!cal_long_out || $past(write_cal)))
		else $error("Long calibration pulse wrong.");

	a_cal_rsvd_ignore: assert property (
		s_write_at(lmr_pkg::ADDR_IO_CALIBRATION) ##0 !cal_known
		|=> !(cal_init_out || cal_long_out || cal_short_out || cal_reset_out))
		else $error("Reserved calibration code started an action.");

	a_tied_no_cal: assert property (
		strap_taken_r && strap_tied_r ##1 1'b1
		|-> !(cal_init_out || cal_long_out || cal_short_out || cal_reset_out) && default_cal_out)
		else $error("Calibration ran with pin tied to supply.");

	a_default_select: assert property (
		s_cal_write ##0 operand_bits_in == lmr_pkg::CAL_SHORT |=> ##1 !default_cal_out)
		else $error("Active calibration did not leave default mode.");

	a_mask_store: assert property (
		s_write_at(lmr_pkg::ADDR_BANK_MASK)
		|=> partial_refresh_bank_mask_out == ($past(operand_bits_in) & bank_enable))
		else $error("Bank mask write not stored.");

	a_mask_high_off: assert property (
		NUM_BANKS == 4 |-> partial_refresh_bank_mask_out[7:4] == 4'h0)
		else $error("Mask bits above bank three took effect.");

	a_rsvd_write: assert property (
		mode_write_in && register_address_in >= lmr_pkg::ADDR_RESERVED_FIRST
		&& register_address_in <= lmr_pkg::ADDR_RESERVED_LAST
		|=> $stable(test_mode_out) && $stable(partial_refresh_bank_mask_out)
		&& !cal_long_out && !cal_reset_out)
		else $error("Reserved address write changed state.");
endmodule

// ### hdl/lmr_pkg.sv
package lmr_pkg;
	// Mode register addresses served by this block.
	localparam logic [7:0] ADDR_REVISION_TWO   = 8'h07;
	localparam logic [7:0] ADDR_ORGANISATION   = 8'h08;
	localparam logic [7:0] ADDR_TEST_MODE      = 8'h09;
	localparam logic [7:0] ADDR_IO_CALIBRATION = 8'h0a;
	localparam logic [7:0] ADDR_RESERVED_FIRST = 8'h0b;
	localparam logic [7:0] ADDR_RESERVED_LAST  = 8'h0f;
	localparam logic [7:0] ADDR_BANK_MASK      = 8'h10;

	// Organisation register field positions.
	localparam int ORG_TYPE_LSB    = 0;
	localparam int ORG_DENSITY_LSB = 2;
	localparam int ORG_WIDTH_LSB   = 6;

	// Memory type codes.
	localparam logic [1:0] TYPE_S4_SDRAM = 2'h0;
	localparam logic [1:0] TYPE_S2_SDRAM = 2'h1;
	localparam logic [1:0] TYPE_NVM      = 2'h2;

	// Density codes, doubling from 64Mb; codes above the 32Gb code are reserved.
	localparam logic [3:0] DENSITY_64MB = 4'h0;
	localparam logic [3:0] DENSITY_2GB  = 4'h5;
	localparam logic [3:0] DENSITY_32GB = 4'h9;

	// Data bus width codes.
	localparam logic [1:0] WIDTH_X32 = 2'h0;
	localparam logic [1:0] WIDTH_X16 = 2'h1;
	localparam logic [1:0] WIDTH_X8  = 2'h2;

	// Calibration command codes.
	localparam logic [7:0] CAL_AFTER_INIT = 8'hff;
	localparam logic [7:0] CAL_LONG       = 8'hab;
	localparam logic [7:0] CAL_SHORT      = 8'h56;
	localparam logic [7:0] CAL_RESET      = 8'hc3;

	// Reset values, the harmless answer for unreadable addresses and the default bank count.
	localparam logic [7:0] TEST_MODE_RESET = 8'h00;
	localparam logic [7:0] BANK_MASK_RESET = 8'h00;
	localparam logic [7:0] READ_FILL       = 8'h00;
	localparam int         BANKS_DEFAULT   = 8;

	typedef enum logic [1:0] {
		LMR_CAL_INIT,
		LMR_CAL_LONG,
		LMR_CAL_SHORT,
		LMR_CAL_RESET
	} lmr_cal_kind_t;
endpackage

// ### hdl/lmr_cal_decode.sv
`timescale 1ns/10ps
module lmr_cal_decode (
	input  wire logic [7:0] code_in,
	output logic            known_out,
	output logic [3:0]      kind_onehot_out
);
	// A code outside the four commands decodes to nothing, so it starts no action.
	always_comb begin
		kind_onehot_out = 4'h0;
		known_out       = 1'b1;
		case (code_in)
			lmr_pkg::CAL_AFTER_INIT: kind_onehot_out[lmr_pkg::LMR_CAL_INIT] = 1'b1;
			lmr_pkg::CAL_LONG:       kind_onehot_out[lmr_pkg::LMR_CAL_LONG] = 1'b1;
			lmr_pkg::CAL_SHORT:      kind_onehot_out[lmr_pkg::LMR_CAL_SHORT] = 1'b1;
			lmr_pkg::CAL_RESET:      kind_onehot_out[lmr_pkg::LMR_CAL_RESET] = 1'b1;
			default:                 known_out = 1'b0;
		endcase
	end
endmodule

// ### bench/lmr_ctrl_model.sv
`timescale 1ns/10ps
module lmr_ctrl_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] read_data_in,
	input  wire logic       read_valid_in,
	output logic            mode_write_out,
	output logic            mode_read_out,
	output logic [7:0]      register_address_out,
	output logic [7:0]      operand_bits_out
);
	initial begin
		mode_write_out = 1'b0;
		mode_read_out = 1'b0;
		register_address_out = 8'h00;
		operand_bits_out = 8'h00;
	end
	// Idle lines carry the inverse of the last command, so sampling them off a strobe fails.
	task automatic issue(input logic wr, input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_in);
		#1;
		mode_write_out = wr;
		mode_read_out = !wr;
		register_address_out = addr;
		operand_bits_out = data;
		@(posedge clk_in);
		#1;
		mode_write_out = 1'b0;
		mode_read_out = 1'b0;
		register_address_out = ~addr;
		operand_bits_out = ~data;
	endtask
	// Reserved calibration codes, test codes and reserved addresses are sent only when a
	// scenario asks for them; the bench then checks that reserved ones start nothing and test codes are stored.
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		issue(1'b1, addr, data);
	endtask
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic vld);
		issue(1'b0, addr, 8'h00);
		data = read_data_in;
		vld = read_valid_in;
	endtask
endmodule

// ### bench/lmr_mode_regs_bench.sv
`timescale 1ns/10ps
module lmr_mode_regs_bench;
	localparam logic [7:0] REV_CODE = 8'h3c; // Arbitrary value.
	localparam logic [7:0] ORG      = {lmr_pkg::WIDTH_X16, lmr_pkg::DENSITY_32GB,
	                                   lmr_pkg::TYPE_S2_SDRAM};
	logic       clk_in = 1'b0;
	logic       nrst_in = 1'b0;
	logic       tied = 1'b0;
	logic       wr, rd, rvalid, cal_i, cal_l, cal_s, cal_r, dflt, strap, vld;
	logic [7:0] addr, wdata, rdata, tmode, mask, got;
	logic [7:0] codes [8] = '{8'hff, 8'h00, 8'hab, 8'hfe, 8'h56, 8'h57, 8'hc3, 8'hc2};
	logic [3:0] pulse [8] = '{4'h8, 4'h0, 4'h4, 4'h0, 4'h2, 4'h0, 4'h1, 4'h0};
	logic       dexp [8]  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	int         errors = 0;
	int         n_compared = 0;
	always #25 clk_in = ~clk_in;
	lmr_ctrl_model u_ctrl (.clk_in(clk_in), .read_data_in(rdata), .read_valid_in(rvalid),
		.mode_write_out(wr), .mode_read_out(rd), .register_address_out(addr),
		.operand_bits_out(wdata));
	lmr_mode_regs #(.REVISION_CODE(REV_CODE), .MEM_TYPE(lmr_pkg::TYPE_S2_SDRAM),
		.DENSITY(lmr_pkg::DENSITY_32GB), .IO_WIDTH(lmr_pkg::WIDTH_X16), .NUM_BANKS(4)
	) u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .mode_write_in(wr), .mode_read_in(rd),
		.register_address_in(addr), .operand_bits_in(wdata),
		.calibration_pin_to_supply_in(tied), .operand_bits_out(rdata),
		.read_valid_out(rvalid), .test_mode_out(tmode), .partial_refresh_bank_mask_out(mask),
		.cal_init_out(cal_i), .cal_long_out(cal_l), .cal_short_out(cal_s),
		.cal_reset_out(cal_r), .default_cal_out(dflt), .strap_valid_out(strap));
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t ns: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic end_sim();
		if (errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// The strap is sampled once per reset, so the tied-pin case needs a fresh reset.
	task automatic do_reset(input logic pin);
		@(posedge clk_in);
		#1;
		nrst_in = 1'b0;
		tied = pin;
		repeat (10) @(posedge clk_in);
		#1;
		nrst_in = 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
	endtask
	initial begin
		#200000;
		errors++;
		end_sim();
	end
	initial begin
		do_reset(1'b0);
		check({2'h0, dflt, strap, cal_i, cal_l, cal_s, cal_r}, 8'h30);
		for (int a = 7; a < 16; a++) begin
			if (a != 9 && a != 10) begin
				u_ctrl.write_reg(8'(a), 8'hff);
			end
		end
		check({2'h0, dflt, strap, cal_i, cal_l, cal_s, cal_r}, 8'h30);
		check(mask, lmr_pkg::BANK_MASK_RESET);
		check(tmode, lmr_pkg::TEST_MODE_RESET);
		u_ctrl.write_reg(lmr_pkg::ADDR_TEST_MODE, 8'ha5);
		check(tmode, 8'ha5);
		u_ctrl.write_reg(lmr_pkg::ADDR_BANK_MASK, 8'h5a);
		check(mask, 8'h0a);
		u_ctrl.write_reg(lmr_pkg::ADDR_BANK_MASK, 8'hf5);
		check(mask, 8'h05);
		for (int a = 7; a <= 16; a++) begin
			u_ctrl.read_reg(8'(a), got, vld);
			check({7'h0, vld}, 8'h01);
			check(got, (a == 7) ? REV_CODE : (a == 8) ? ORG :
				lmr_pkg::READ_FILL);
		end
		for (int i = 0; i < 8; i++) begin
			u_ctrl.write_reg(lmr_pkg::ADDR_IO_CALIBRATION, codes[i]);
			check({4'h0, cal_i, cal_l, cal_s, cal_r}, {4'h0, pulse[i]});
			@(posedge clk_in);
			#1;
			check({7'h0, dflt}, {7'h0, dexp[i]});
		end
		do_reset(1'b1);
		for (int i = 0; i < 8; i++) begin
			u_ctrl.write_reg(lmr_pkg::ADDR_IO_CALIBRATION, codes[i]);
			check({2'h0, dflt, strap, cal_i, cal_l, cal_s, cal_r}, 8'h30);
		end
		end_sim();
	end
endmodule
